// ==== rtl/timer_two_pkg.sv ====
package timer_two_pkg;
    // register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_CONTROL = 8'hc8;
    localparam logic [7:0] IDX_MODE = 8'hc9;
    localparam logic [7:0] IDX_CAP_LOW = 8'hca;
    localparam logic [7:0] IDX_CAP_HIGH = 8'hcb;
    localparam logic [7:0] IDX_COUNT_LOW = 8'hcc;
    localparam logic [7:0] IDX_COUNT_HIGH = 8'hcd;
    localparam int ADDR_W = 12;
    // control register fields
    localparam int BIT_OVF = 7;
    localparam int BIT_EXF = 6;
    localparam int BIT_RCLK_SEL = 5;
    localparam int BIT_TCLK_SEL = 4;
    localparam int BIT_EXT_EN = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_CT_SEL = 1;
    localparam int BIT_CR_SEL = 0;
    // mode register fields
    localparam int BIT_CAP_RST = 3;
    localparam int BIT_DOWN_EN = 0;
    localparam logic [7:0] MODE_MASK = 8'h09;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // tick periods in clocks
    localparam logic [3:0] DIV_SLOW = 4'd12;
    localparam logic [3:0] DIV_FAST = 4'd4;
    localparam logic [3:0] DIV_BAUD = 4'd2;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== rtl/tick_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
module tick_divider
    import timer_two_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // control
    input wire logic enable,
    input wire logic [3:0] period,
    // tick out
    output logic tick
);
    logic [3:0] cnt_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 4'h0;
        end else if (!enable || cnt_q >= period - 4'd1) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'd1;
        end
    end

    assign tick = enable && (cnt_q >= period - 4'd1);

    p_tick_spacing: assert property (@(posedge clk_sys) disable iff (!arst_n)
        tick && enable && period == DIV_BAUD |=> !tick)
        else $error("divider ticked on consecutive cycles");
endmodule
`default_nettype wire

// ==== rtl/timer_two.sv ====
`timescale 1ns/1ps
`default_nettype none
module timer_two
    import timer_two_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic trigger_pin,
    input wire logic external_count_pin,
    input wire logic timer_clock_divider_select,
    input wire logic timer_two_irq_enable,
    // toward serial port and interrupt logic
    output logic rx_baud_tick,
    output logic tx_baud_tick,
    output logic timer_two_irq
);
    ////////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a, output logic hit);
        logic [ADDR_W-1:0] idx;
        idx = a >> 2;
        hit = (a[1:0] == 2'b00) && idx >= ADDR_W'(IDX_CONTROL)
              && idx <= ADDR_W'(IDX_COUNT_HIGH);
        reg_sel = 3'(idx - ADDR_W'(IDX_CONTROL));
    endfunction

    logic [7:0] control_q;
    logic [7:0] mode_q;
    logic [7:0] cap_low_q;
    logic [7:0] cap_high_q;
    logic [15:0] count_q;
    logic trig_q;
    logic cpin_q;

    ////////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order
    logic aw_held_q, w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic wstrb0_q;
    logic wr_fire;
    logic wr_hit;
    logic [2:0] wr_sel;

    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = !w_held_q && !s_axi_bvalid;
    assign wr_fire = aw_held_q && w_held_q;

    always_comb begin
        wr_hit = 1'b0;
        wr_sel = reg_sel(awaddr_q, wr_hit);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0;
            wstrb0_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // only lane 0 carries register data
    logic wr_en;
    assign wr_en = wr_fire && wr_hit && wstrb0_q;

    ////////////////////////////////////////////////////////////////////////
    // read channel
    logic rd_hit;
    logic [2:0] rd_sel;
    logic [7:0] rd_byte;

    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_hit = 1'b0;
        rd_sel = reg_sel(s_axi_araddr, rd_hit);
        case (rd_sel)
            3'd0: rd_byte = control_q;
            3'd1: rd_byte = mode_q;
            3'd2: rd_byte = cap_low_q;
            3'd3: rd_byte = cap_high_q;
            3'd4: rd_byte = count_q[7:0];
            3'd5: rd_byte = count_q[15:8];
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h0, rd_hit ? rd_byte : 8'h00};
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode decode
    logic baud_mode, run, ext_en, cap_mode, down_en;
    assign baud_mode = control_q[BIT_RCLK_SEL] || control_q[BIT_TCLK_SEL];
    assign run = control_q[BIT_RUN];
    assign ext_en = control_q[BIT_EXT_EN];
    assign cap_mode = control_q[BIT_CR_SEL] && !baud_mode;
    assign down_en = mode_q[BIT_DOWN_EN] && !cap_mode && !baud_mode;

    // trigger and count pins are taken as synchronous
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            trig_q <= 1'b1;
            cpin_q <= 1'b1;
        end else begin
            trig_q <= trigger_pin;
            cpin_q <= external_count_pin;
        end
    end

    logic trig_fall, cpin_fall, trig_event;
    assign trig_fall = trig_q && !trigger_pin;
    assign cpin_fall = cpin_q && !external_count_pin;
    // direction pin doubles as trigger; down mode uses its level instead
    assign trig_event = trig_fall && ext_en && !baud_mode && !down_en;

    ////////////////////////////////////////////////////////////////////////
    // tick generation
    logic div_tick;
    logic [3:0] div_period;
    logic use_div;
    assign use_div = run && (baud_mode || !control_q[BIT_CT_SEL]);
    assign div_period = baud_mode ? DIV_BAUD :
        (timer_clock_divider_select ? DIV_FAST : DIV_SLOW);

    tick_divider u_div (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .enable(use_div),
        .period(div_period),
        .tick(div_tick)
    );

    logic tick;
    assign tick = run && (baud_mode || !control_q[BIT_CT_SEL] ? div_tick : cpin_fall);

    ////////////////////////////////////////////////////////////////////////
    // counter
    logic count_up;
    logic [15:0] reload_val;
    logic wrap_up, hit_down, ovf_event;
    assign count_up = !down_en || trigger_pin;
    assign reload_val = {cap_high_q, cap_low_q};
    assign wrap_up = tick && count_up && count_q == 16'hffff;
    assign hit_down = tick && !count_up && count_q == reload_val;
    assign ovf_event = wrap_up || hit_down;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= 16'h0000;
        end else if (wr_en && wr_sel == 3'd4) begin
            count_q[7:0] <= wdata_q[7:0];
        end else if (wr_en && wr_sel == 3'd5) begin
            count_q[15:8] <= wdata_q[7:0];
        end else if (cap_mode && trig_event && mode_q[BIT_CAP_RST]) begin
            count_q <= 16'h0000;
        end else if (!cap_mode && trig_event) begin
            count_q <= reload_val;
        end else if (wrap_up && !cap_mode) begin
            count_q <= reload_val;
        end else if (hit_down) begin
            count_q <= 16'hffff;
        end else if (tick) begin
            count_q <= count_up ? count_q + 16'd1 : count_q - 16'd1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cap_low_q <= BYTE_RESET;
            cap_high_q <= BYTE_RESET;
        end else if (cap_mode && trig_event) begin
            cap_low_q <= count_q[7:0];
            cap_high_q <= count_q[15:8];
        end else if (wr_en && wr_sel == 3'd2) begin
            cap_low_q <= wdata_q[7:0];
        end else if (wr_en && wr_sel == 3'd3) begin
            cap_high_q <= wdata_q[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control and mode registers; hardware set wins over a software write
    logic ovf_set, exf_set;
    assign ovf_set = ovf_event && !baud_mode;
    assign exf_set = trig_event || (down_en && ovf_event);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            control_q <= CONTROL_RESET;
        end else begin
            if (wr_en && wr_sel == 3'd0) begin
                control_q <= wdata_q[7:0];
            end
            if (ovf_set) begin
                control_q[BIT_OVF] <= 1'b1;
            end
            if (exf_set) begin
                control_q[BIT_EXF] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_q <= MODE_RESET;
        end else if (wr_en && wr_sel == 3'd1) begin
            mode_q <= wdata_q[7:0] & MODE_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    logic baud_tick_q;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            baud_tick_q <= 1'b0;
        end else begin
            baud_tick_q <= wrap_up && baud_mode;
        end
    end
    assign rx_baud_tick = baud_tick_q && control_q[BIT_RCLK_SEL];
    assign tx_baud_tick = baud_tick_q && control_q[BIT_TCLK_SEL];
    // level request while either flag stands
    assign timer_two_irq = timer_two_irq_enable
        && (control_q[BIT_EXF] || control_q[BIT_OVF]);

    ////////////////////////////////////////////////////////////////////////
    // checks
    p_ovf_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ovf_set |=> control_q[BIT_OVF])
        else $error("overflow flag not set");
    p_no_ovf_baud: assert property (@(posedge clk_sys) disable iff (!arst_n)
        baud_mode && !(wr_en && wr_sel == 3'd0) |=> !$rose(control_q[BIT_OVF]))
        else $error("overflow flag set in baud mode");
    p_exf_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
        trig_event |=> control_q[BIT_EXF])
        else $error("external flag missed edge");
    p_irq: assert property (@(posedge clk_sys) disable iff (!arst_n)
        control_q[BIT_EXF] && timer_two_irq_enable |-> timer_two_irq)
        else $error("interrupt request missing");
    p_ignore: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (baud_mode || !ext_en) |-> !trig_event)
        else $error("trigger not ignored");
    p_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !run && !wr_en && !trig_event |=> $stable(count_q))
        else $error("count moved while stopped");
    p_capture: assert property (@(posedge clk_sys) disable iff (!arst_n)
        cap_mode && trig_event |=> cap_low_q == $past(count_q[7:0])
            && cap_high_q == $past(count_q[15:8]))
        else $error("capture mismatch");
    p_reload: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wrap_up && !cap_mode && !wr_en && !trig_event |=> count_q == $past(reload_val))
        else $error("reload mismatch");
    p_cap_rst: assert property (@(posedge clk_sys) disable iff (!arst_n)
        cap_mode && trig_event && mode_q[BIT_CAP_RST] && !wr_en |=> count_q == 16'h0000)
        else $error("capture reset failed");
    // underflow against the reload value restarts from the top
    p_down_wrap: assert property (@(posedge clk_sys) disable iff (!arst_n)
        hit_down && !wr_en |=> count_q == 16'hffff)
        else $error("down count did not wrap");
    p_down_step: assert property (@(posedge clk_sys) disable iff (!arst_n)
        tick && down_en && !trigger_pin && count_q != reload_val && !wr_en
            |=> count_q == $past(count_q) - 16'd1)
        else $error("down count step wrong");
    p_baud_pulse: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wrap_up && baud_mode && !wr_en |=> rx_baud_tick == control_q[BIT_RCLK_SEL])
        else $error("receive baud pulse missing");
    p_no_cap_baud: assert property (@(posedge clk_sys) disable iff (!arst_n)
        baud_mode && !wr_en |=> $stable(cap_low_q) && $stable(cap_high_q))
        else $error("capture registers moved in baud mode");
    p_trig_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
        trig_fall && !ext_en && !wr_en && !tick |=> $stable(count_q))
        else $error("disabled trigger moved the count");
endmodule
`default_nettype wire

// ==== tb/pin_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // requests from the bench
    input wire logic trig_lvl,
    input wire logic cnt_en,
    // baud pulses from the timer
    input wire logic rx_baud_tick,
    input wire logic tx_baud_tick,
    // pins and tick tallies
    output logic trigger_pin,
    output logic external_count_pin,
    output logic [7:0] rx_n,
    output logic [7:0] tx_n
);
    logic [3:0] ph_q;
    // pins move only just after an edge; one falling count edge per 4 clocks
    always_ff @(posedge clk_sys) begin
        trigger_pin <= trig_lvl;
        ph_q <= cnt_en ? ph_q + 4'h1 : 4'h0;
    end
    assign external_count_pin = ~ph_q[1];
    ////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_n <= 8'h00;
            tx_n <= 8'h00;
        end else begin
            rx_n <= rx_n + 8'(rx_baud_tick);
            tx_n <= tx_n + 8'(tx_baud_tick);
        end
    end
endmodule
`default_nettype wire

// ==== tb/test_timer2_capture_reload_baud.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_timer2_capture_reload_baud
    import timer_two_pkg::*;
;
    localparam logic [7:0] OVF = 8'(1 << BIT_OVF);
    localparam logic [7:0] EXF = 8'(1 << BIT_EXF);
    localparam logic [7:0] BAUD = 8'(1 << BIT_RCLK_SEL) | 8'(1 << BIT_TCLK_SEL);
    localparam logic [7:0] EXT = 8'(1 << BIT_EXT_EN);
    localparam logic [7:0] RUN = 8'(1 << BIT_RUN);
    localparam logic [7:0] CNT = 8'(1 << BIT_CT_SEL);
    localparam logic [7:0] CAP = 8'(1 << BIT_CR_SEL);
    typedef struct packed {logic [7:0] idx; logic [7:0] wv; logic [7:0] ev;} row_t;
    row_t rows [6] = '{'{IDX_CAP_LOW, 8'ha5, 8'ha5}, '{IDX_CAP_HIGH, 8'h5a, 8'h5a},
        '{IDX_MODE, 8'hff, MODE_MASK}, '{IDX_COUNT_LOW, 8'h3c, 8'h3c},
        '{IDX_COUNT_HIGH, 8'hc3, 8'hc3}, '{IDX_CONTROL, 8'h00, 8'h00}};
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic [31:0] rd_q;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, trig_pin, cnt_pin, rx_t, tx_t, irq;
    logic [1:0] bresp, rresp, resp_q;
    logic trig_lvl = 1'b1, cnt_en = 1'b0, div_sel = 1'b1, irq_en = 1'b1;
    logic [7:0] rx_n, tx_n;
    int n_mismatch = 0;
    int tests_run = 0;

    timer_two timer_two_i (
        .clk_sys(clk_sys), .arst_n(arst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .trigger_pin(trig_pin), .external_count_pin(cnt_pin),
        .timer_clock_divider_select(div_sel), .timer_two_irq_enable(irq_en),
        .rx_baud_tick(rx_t), .tx_baud_tick(tx_t), .timer_two_irq(irq)
    );
    pin_partner pin_partner_i (
        .clk_sys(clk_sys), .arst_n(arst_n), .trig_lvl(trig_lvl), .cnt_en(cnt_en),
        .rx_baud_tick(rx_t), .tx_baud_tick(tx_t), .trigger_pin(trig_pin),
        .external_count_pin(cnt_pin), .rx_n(rx_n), .tx_n(tx_n)
    );
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // ready is sampled at the falling edge: nothing moves between it and the next rise
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic ta, tw, tb;
        @(posedge clk_sys);
        awaddr <= {2'b00, idx, 2'b00};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (40) begin
            @(negedge clk_sys);
            ta = awready & awvalid;
            tw = wready & wvalid;
            tb = bvalid;
            resp_q = bresp;
            @(posedge clk_sys);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                return;
            end
        end
        n_mismatch++;
        end_of_test();
    endtask
    task automatic rd(input logic [7:0] idx);
        logic ta, tv;
        @(posedge clk_sys);
        araddr <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        repeat (40) begin
            @(negedge clk_sys);
            ta = arready & arvalid;
            tv = rvalid;
            rd_q = rdata;
            resp_q = rresp;
            @(posedge clk_sys);
            if (ta) arvalid <= 1'b0;
            if (tv) begin
                rready <= 1'b0;
                return;
            end
        end
        n_mismatch++;
        end_of_test();
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [7:0] e, input string what);
        rd(idx);
        chk(what, {24'h000000, e}, rd_q);
    endtask
    task automatic set16(input logic [7:0] lo, input logic [15:0] v);
        wr(lo, v[7:0]);
        wr(lo + 8'h01, v[15:8]);
    endtask
    task automatic fall();
        trig_lvl <= 1'b0;
        repeat (4) @(posedge clk_sys);
        trig_lvl <= 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        foreach (rows[i]) rchk(rows[i].idx, BYTE_RESET, "reset value");
        foreach (rows[i]) begin
            wr(rows[i].idx, rows[i].wv);
            rchk(rows[i].idx, rows[i].ev, "readback");
        end
        rd(8'hce);
        chk("unmapped read", 32'(RESP_SLVERR), 32'(resp_q));
        wr(8'hce, 8'h11);
        chk("unmapped write", 32'(RESP_SLVERR), 32'(resp_q));
        $display("registers done");
        wr(IDX_MODE, 8'h00);
        set16(IDX_CAP_LOW, 16'hfffe);
        set16(IDX_COUNT_LOW, 16'hfffe);
        wr(IDX_CONTROL, RUN);
        repeat (40) @(posedge clk_sys);
        rchk(IDX_CONTROL, OVF | RUN, "overflow flag");
        chk("irq", 32'h1, 32'(irq));
        wr(IDX_CONTROL, OVF);
        rchk(IDX_COUNT_HIGH, 8'hff, "reloaded high");
        wr(IDX_CONTROL, 8'h00);
        rchk(IDX_CONTROL, 8'h00, "flag cleared");
        // roughly 124 clocks of run: 10 ticks at the slow rate, 31 at the fast
        div_sel <= 1'b0;
        set16(IDX_COUNT_LOW, 16'h0000);
        wr(IDX_CONTROL, RUN);
        repeat (120) @(posedge clk_sys);
        wr(IDX_CONTROL, 8'h00);
        rd(IDX_COUNT_LOW);
        chk("slow rate", 32'h1, 32'(rd_q >= 8 && rd_q <= 12));
        rchk(IDX_COUNT_LOW, rd_q[7:0], "held count");
        div_sel <= 1'b1;
        $display("overflow done");
        wr(IDX_CONTROL, EXT);
        set16(IDX_CAP_LOW, 16'h1234);
        set16(IDX_COUNT_LOW, 16'h0000);
        fall();
        rchk(IDX_COUNT_LOW, 8'h34, "trigger reload");
        rchk(IDX_CONTROL, EXF | EXT, "external flag");
        chk("irq", 32'h1, 32'(irq));
        wr(IDX_CONTROL, 8'h00);
        set16(IDX_COUNT_LOW, 16'h0000);
        fall();
        rchk(IDX_COUNT_LOW, 8'h00, "trigger ignored");
        rchk(IDX_CONTROL, 8'h00, "no flag");
        $display("reload done");
        wr(IDX_MODE, 8'(1 << BIT_CAP_RST));
        set16(IDX_COUNT_LOW, 16'h4321);
        wr(IDX_CONTROL, EXT | CAP);
        fall();
        rchk(IDX_CAP_LOW, 8'h21, "capture low");
        rchk(IDX_CAP_HIGH, 8'h43, "capture high");
        rchk(IDX_COUNT_LOW, 8'h00, "count cleared");
        rchk(IDX_COUNT_HIGH, 8'h00, "count cleared");
        wr(IDX_MODE, 8'h00);
        set16(IDX_COUNT_LOW, 16'h0000);
        wr(IDX_CONTROL, RUN | CNT);
        cnt_en <= 1'b1;
        repeat (20) @(posedge clk_sys);
        cnt_en <= 1'b0;
        wr(IDX_CONTROL, 8'h00);
        rchk(IDX_COUNT_LOW, 8'h05, "pin edges");
        $display("capture and counter done");
        // capture select set on purpose: baud mode must still reload, not capture
        set16(IDX_CAP_LOW, 16'hfff0);
        set16(IDX_COUNT_LOW, 16'hfff0);
        wr(IDX_CONTROL, BAUD | RUN | EXT | CAP);
        fall();
        repeat (200) @(posedge clk_sys);
        rchk(IDX_CONTROL, BAUD | RUN | EXT | CAP, "baud flags");
        wr(IDX_CONTROL, 8'h00);
        chk("rx ticks", 32'h1, 32'(rx_n >= 5 && rx_n <= 9));
        chk("tx ticks", 32'(rx_n), 32'(tx_n));
        rchk(IDX_CAP_LOW, 8'hf0, "no capture");
        $display("baud done");
        wr(IDX_MODE, 8'(1 << BIT_DOWN_EN));
        set16(IDX_CAP_LOW, 16'h0000);
        set16(IDX_COUNT_LOW, 16'h0003);
        trig_lvl <= 1'b0;
        wr(IDX_CONTROL, RUN);
        repeat (40) @(posedge clk_sys);
        rchk(IDX_CONTROL, OVF | EXF | RUN, "down match");
        wr(IDX_CONTROL, 8'h00);
        rchk(IDX_COUNT_HIGH, 8'hff, "down wrap");
        trig_lvl <= 1'b1;
        $display("down count done");
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        rchk(IDX_MODE, MODE_RESET, "second reset");
        rchk(IDX_COUNT_HIGH, BYTE_RESET, "second reset");
        $display("reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
